// [hw/rtc_status_irq.sv]
// rtc status flags, interrupt control and interrupt outputs
`timescale 1ns/1ps
// Summary of operation
// - the reset flag in bit 7 is 1 after reset and clears on a write of one.
// - the alarm flag in bit 6 sets on each alarm while alarm enable is set; writing one clears it.
// - the alarm interrupt output holds low until the alarm flag is cleared.
// - each periodic interrupt is one 15 us low pulse, needing no acknowledge.
// - bits 5..2 are read-only day/hour/minute/second flags, reset 0.
// - bit 1 shows the true run state: 0 frozen, 1 running.
// - the run control is resynchronised to the 32 kHz clock before it shows.
// - with the sleep hold bit set, periodic interrupts in sleep wait for wake.
// - with alarm enable set, an alarm match raises one alarm interrupt.
// - periodic enable bit 2 gates the periodic interrupt.
// - period bits 1:0 pick second, minute, hour or day; reset 00.
// - the run control freezes the clock at 0 and runs it at 1.
module rtc_status_irq
#(
   parameter int PULSE_LEN = rtc_status_pkg::PULSE_CYCLES
)
(
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   // register access port from the control-bus transport
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // counter core
   input  wire logic       tick_32k_i,
   input  wire logic       run_ctrl_i,
   input  wire logic       second_evt_i,
   input  wire logic       minute_evt_i,
   input  wire logic       hour_evt_i,
   input  wire logic       day_evt_i,
   input  wire logic       alarm_match_i,
   input  wire logic       sleep_i,
   // interrupt lines, active low, and the run state, active high
   output logic            alarm_irq_n_o,
   output logic            periodic_irq_n_o,
   output logic            run_state_o
);
   typedef enum logic [1:0]
   {
      PULSE_IDLE = 2'b01,
      PULSE_LOW  = 2'b10
   } pulse_state_t;

   logic             run_sync;
   logic             run_r;
   logic             run_nxt;
   logic             power_up_r;
   logic             power_up_nxt;
   logic             alarm_flag_r;
   logic             alarm_flag_nxt;
   logic [3:0]       evt_r;
   logic [3:0]       evt_nxt;
   logic [7:0]       ctrl_r;
   logic [7:0]       ctrl_nxt;
   logic [7:0]       status_snap_r;
   logic [7:0]       status_snap_nxt;
   logic [7:0]       rdata_nxt;
   logic             held_r;
   logic             held_nxt;
   pulse_state_t     pst_r;
   pulse_state_t     pst_nxt;
   logic [rtc_status_pkg::PULSE_CNT_W-1:0] cnt_r;
   logic [rtc_status_pkg::PULSE_CNT_W-1:0] cnt_nxt;
   logic             periodic_n_nxt;
   logic             alarm_n_nxt;
   logic             wr_status;
   logic             wr_ctrl;
   logic             sel_evt;
   logic             fire;
   logic [7:0]       status_live;

   // run control crosses into the 32 kHz timing before it shows
   rtc_sync2 u_run_sync
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .d_i        (run_ctrl_i),
      .q_o        (run_sync)
   );

   always_comb
   begin
      wr_status = reg_wr_i && (reg_addr_i == rtc_status_pkg::STATUS_OFFSET);
      wr_ctrl   = reg_wr_i && (reg_addr_i == rtc_status_pkg::IRQ_CTRL_OFFSET);

      // run indicator only moves on a 32 kHz tick
      run_nxt = tick_32k_i ? run_sync : run_r;

      // set wins over a simultaneous write-one clear
      power_up_nxt = power_up_r;
      if (wr_status && reg_wdata_i[rtc_status_pkg::POWER_UP_BIT])
         power_up_nxt = 1'b0;

      alarm_flag_nxt = alarm_flag_r;
      if (wr_status && reg_wdata_i[rtc_status_pkg::ALARM_FLAG_BIT])
         alarm_flag_nxt = 1'b0;
      if (alarm_match_i && ctrl_r[rtc_status_pkg::ALARM_EN_BIT])
         alarm_flag_nxt = 1'b1;
      alarm_n_nxt = ~alarm_flag_nxt;

      // elapsed flags stay until the next status read
      evt_nxt = evt_r;
      if (reg_rd_i && (reg_addr_i == rtc_status_pkg::STATUS_OFFSET))
         evt_nxt = 4'h0;
      evt_nxt = evt_nxt
              | {day_evt_i, hour_evt_i, minute_evt_i, second_evt_i};

      ctrl_nxt = ctrl_r;
      if (wr_ctrl)
         ctrl_nxt = reg_wdata_i & rtc_status_pkg::IRQ_CTRL_WMASK;

      status_live = 8'h00;
      status_live[rtc_status_pkg::POWER_UP_BIT]   = power_up_r;
      status_live[rtc_status_pkg::ALARM_FLAG_BIT] = alarm_flag_r;
      status_live[rtc_status_pkg::DAY_BIT:rtc_status_pkg::SECOND_BIT] = evt_r;
      status_live[rtc_status_pkg::RUN_BIT] = run_r;

      // each status read refreshes the snapshot the next read returns
      status_snap_nxt = status_snap_r;
      if (reg_rd_i && (reg_addr_i == rtc_status_pkg::STATUS_OFFSET))
         status_snap_nxt = status_live;

      case (reg_addr_i)
         rtc_status_pkg::STATUS_OFFSET:   rdata_nxt = status_snap_r;
         rtc_status_pkg::IRQ_CTRL_OFFSET: rdata_nxt = ctrl_r;
         default:                         rdata_nxt = 8'h00;
      endcase
      // read data holds between reads, so the host may fetch it late
      if (!reg_rd_i)
         rdata_nxt = reg_rdata_o;

      case (ctrl_r[rtc_status_pkg::PERIOD_LSB +: 2])
         rtc_status_pkg::PERIOD_SECOND: sel_evt = second_evt_i;
         rtc_status_pkg::PERIOD_MINUTE: sel_evt = minute_evt_i;
         rtc_status_pkg::PERIOD_HOUR:   sel_evt = hour_evt_i;
         rtc_status_pkg::PERIOD_DAY:    sel_evt = day_evt_i;
         default:                       sel_evt = 1'b0;
      endcase

      // an event seen in sleep is held, then sent after wake
      held_nxt = held_r;
      fire     = 1'b0;
      if (sel_evt && ctrl_r[rtc_status_pkg::PERIODIC_EN_BIT])
      begin
         if (sleep_i && ctrl_r[rtc_status_pkg::SLEEP_HOLD_BIT])
            held_nxt = 1'b1;
         else
            fire = 1'b1;
      end
      if (held_r && !sleep_i)
      begin
         fire     = 1'b1;
         held_nxt = 1'b0;
      end
      if (!ctrl_r[rtc_status_pkg::SLEEP_HOLD_BIT] && !sleep_i)
         held_nxt = held_nxt && !fire;

      pst_nxt        = pst_r;
      cnt_nxt        = cnt_r;
      periodic_n_nxt = 1'b1;
      case (pst_r)
         PULSE_IDLE:
         begin
            if (fire)
            begin
               pst_nxt        = PULSE_LOW;
               cnt_nxt        = rtc_status_pkg::PULSE_CNT_W'(PULSE_LEN - 1);
               periodic_n_nxt = 1'b0;
            end
         end
         PULSE_LOW:
         begin
            if (cnt_r == '0)
               pst_nxt = PULSE_IDLE;
            else
            begin
               cnt_nxt        = cnt_r - 1'b1;
               periodic_n_nxt = 1'b0;
            end
         end
         default:
            pst_nxt = PULSE_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         run_r            <= 1'b0;
         power_up_r       <= rtc_status_pkg::POWER_UP_RESET;
         alarm_flag_r     <= 1'b0;
         evt_r            <= 4'h0;
         ctrl_r           <= rtc_status_pkg::IRQ_CTRL_RESET;
         status_snap_r    <= 8'h00;
         reg_rdata_o      <= 8'h00;
         held_r           <= 1'b0;
         pst_r            <= PULSE_IDLE;
         cnt_r            <= '0;
         periodic_irq_n_o <= 1'b1;
         alarm_irq_n_o    <= 1'b1;
         run_state_o      <= 1'b0;
      end
      else
      begin
         run_r            <= run_nxt;
         power_up_r       <= power_up_nxt;
         alarm_flag_r     <= alarm_flag_nxt;
         evt_r            <= evt_nxt;
         ctrl_r           <= ctrl_nxt;
         status_snap_r    <= status_snap_nxt;
         reg_rdata_o      <= rdata_nxt;
         held_r           <= held_nxt;
         pst_r            <= pst_nxt;
         cnt_r            <= cnt_nxt;
         periodic_irq_n_o <= periodic_n_nxt;
         alarm_irq_n_o    <= alarm_n_nxt;
         run_state_o      <= run_nxt;
      end
   end
endmodule : rtc_status_irq

// [hw/rtc_status_pkg.sv]
// constants for the rtc status and interrupt-control block
package rtc_status_pkg;
   localparam logic [7:0] STATUS_OFFSET      = 8'h11;
   localparam logic [7:0] IRQ_CTRL_OFFSET    = 8'h12;
   localparam int         POWER_UP_BIT       = 7;
   localparam int         ALARM_FLAG_BIT     = 6;
   localparam int         DAY_BIT            = 5;
   localparam int         HOUR_BIT           = 4;
   localparam int         MINUTE_BIT         = 3;
   localparam int         SECOND_BIT         = 2;
   localparam int         RUN_BIT            = 1;
   localparam int         SLEEP_HOLD_BIT     = 4;
   localparam int         ALARM_EN_BIT       = 3;
   localparam int         PERIODIC_EN_BIT    = 2;
   localparam int         PERIOD_LSB         = 0;
   localparam logic [7:0] IRQ_CTRL_WMASK     = 8'h1F;
   localparam logic       POWER_UP_RESET     = 1'b1;
   localparam logic [7:0] IRQ_CTRL_RESET     = 8'h00;
   localparam logic [1:0] PERIOD_SECOND      = 2'h0;
   localparam logic [1:0] PERIOD_MINUTE      = 2'h1;
   localparam logic [1:0] PERIOD_HOUR        = 2'h2;
   localparam logic [1:0] PERIOD_DAY         = 2'h3;
   localparam int         CLK_PERIOD_PS      = 25000;
   localparam int         PULSE_US           = 15;
   localparam int         PULSE_CYCLES       =
      (PULSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int         PULSE_CNT_W        = 10;
endpackage : rtc_status_pkg

// [hw/rtc_sync2.sv]
// two-flop level synchroniser
`timescale 1ns/1ps
module rtc_sync2
(
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   // level
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_r;
   logic meta_nxt;
   logic q_nxt;

   always_comb
   begin
      meta_nxt = d_i;
      q_nxt    = meta_r;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_r <= 1'b0;
         q_o    <= 1'b0;
      end
      else
      begin
         meta_r <= meta_nxt;
         q_o    <= q_nxt;
      end
   end
endmodule : rtc_sync2

// [verif/rtc_host_model.sv]
// host model issuing register cycles to the block
`timescale 1ns/1ps
module rtc_host_model
(
   // clock and read data
   input  wire logic       core_clk_i,
   input  wire logic [7:0] reg_rdata_i,
   // register requests
   output logic      [7:0] reg_addr_o  = 8'h00,
   output logic            reg_wr_o    = 1'b0,
   output logic            reg_rd_o    = 1'b0,
   output logic      [7:0] reg_wdata_o = 8'h00
);
   // released write data is inverted so a stale value never passes
   task automatic wr(input logic [7:0] x, input logic [7:0] v);
      @(posedge core_clk_i);
      reg_addr_o <= x;
      reg_wdata_o <= v;
      reg_wr_o <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~v;
   endtask : wr
   // status only refreshes on the read before, hence two reads
   task automatic rd(input logic [7:0] x, output logic [7:0] v);
      repeat (x == 8'h11 ? 2 : 1)
      begin
         @(posedge core_clk_i);
         reg_addr_o <= x;
         reg_rd_o <= 1'b1;
         @(posedge core_clk_i);
         reg_rd_o <= 1'b0;
         // read data appears one edge after the strobe is taken
         @(posedge core_clk_i);
         v = reg_rdata_i;
      end
   endtask : rd
endmodule : rtc_host_model

// [verif/rtc_status_props.sv]
// port assertions for the rtc status block
`timescale 1ns/1ps
module rtc_status_props #(parameter int PULSE_LEN = 4)
(
   // watched ports
   input wire logic       core_clk_i,
   input wire logic       rst_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       run_ctrl_i,
   input wire logic       alarm_match_i,
   input wire logic       alarm_irq_n_o,
   input wire logic       periodic_irq_n_o,
   input wire logic       run_state_o
);
   logic       clr;
   logic [9:0] low_r;
   assign clr = reg_wr_i && reg_addr_i == 8'h11 && reg_wdata_i[6];
   // pulse width is judged at its end, so no long repetition is needed
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i)
         low_r <= 10'h000;
      else
         low_r <= periodic_irq_n_o ? 10'h000 : low_r + 10'h001;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_alarm_cause: assert property ($fell(alarm_irq_n_o) |->
      $past(alarm_match_i) || $past(alarm_match_i, 2)) else $error("alarm");
   a_alarm_hold: assert property (!alarm_irq_n_o && !clr &&
      !$past(clr) |=> !alarm_irq_n_o) else $error("alarm hold");
   a_alarm_clear: assert property ($rose(alarm_irq_n_o) |->
      $past(clr) || $past(clr, 2)) else $error("alarm clear");
   a_pulse_len: assert property ($rose(periodic_irq_n_o) |->
      low_r == 10'(PULSE_LEN)) else $error("pulse length");
   a_run_sync: assert property ($changed(run_ctrl_i) |=>
      $stable(run_state_o)) else $error("run sync");
   a_ctrl_rsvd: assert property (reg_rd_i && reg_addr_i == 8'h12 |=>
      reg_rdata_o[7:5] == 3'h0) else $error("reserved bits");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h12 |=>
      reg_rdata_o == 8'h00) else $error("unmapped read");
   a_rdata_hold: assert property (!reg_rd_i |=>
      $stable(reg_rdata_o)) else $error("read data moved");
   c_alarm: cover property ($fell(alarm_irq_n_o));
   c_pulse: cover property ($rose(periodic_irq_n_o));
   c_run: cover property ($rose(run_state_o));
endmodule : rtc_status_props
bind rtc_status_irq rtc_status_props #(.PULSE_LEN(PULSE_LEN)) props_i
(
   .core_clk_i       (core_clk_i),
   .rst_n_i          (rst_n_i),
   .reg_addr_i       (reg_addr_i),
   .reg_wr_i         (reg_wr_i),
   .reg_rd_i         (reg_rd_i),
   .reg_wdata_i      (reg_wdata_i),
   .reg_rdata_o      (reg_rdata_o),
   .run_ctrl_i       (run_ctrl_i),
   .alarm_match_i    (alarm_match_i),
   .alarm_irq_n_o    (alarm_irq_n_o),
   .periodic_irq_n_o (periodic_irq_n_o),
   .run_state_o      (run_state_o)
);

// [verif/tb.sv]
// self-checking bench for the rtc status block
`timescale 1ns/1ps
module tb;
   localparam int PL = 4;
   logic       clk = 1'b0;
   logic       rst_n, tick, run_c, slp, airq, pirq, run_st, wr, rd, en;
   logic [4:0] ev;
   logic [7:0] a, wd, q, d;
   logic [1:0] p;
   int         n_mismatch, checks, e, len;
   rtc_status_irq #(.PULSE_LEN(PL)) rtc_status_irq_i (.core_clk_i(clk),
      .rst_n_i(rst_n), .reg_addr_i(a), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_wdata_i(wd), .reg_rdata_o(q), .tick_32k_i(tick),
      .run_ctrl_i(run_c), .second_evt_i(ev[0]), .minute_evt_i(ev[1]),
      .hour_evt_i(ev[2]), .day_evt_i(ev[3]), .alarm_match_i(ev[4]),
      .sleep_i(slp), .alarm_irq_n_o(airq), .periodic_irq_n_o(pirq),
      .run_state_o(run_st));
   rtc_host_model host_i (.core_clk_i(clk), .reg_rdata_i(q),
      .reg_addr_o(a), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wd));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk)
      tick <= $urandom % 8 == 0;
   task automatic cmp(input logic [7:0] g, input logic [7:0] x);
      checks++;
      if (g !== x)
      begin
         n_mismatch++;
         $display("Error %0t got %h want %h", $time, g, x);
      end
   endtask : cmp
   // pulses event k (k of 5 drives nothing), then measures the periodic line
   task automatic fire(input int k);
      @(posedge clk);
      ev <= 5'h01 << k;
      @(posedge clk);
      ev <= 5'h00;
      len = 0;
      for (int i = 0; i < 8 && pirq !== 1'b0; i++)
         @(posedge clk);
      while (pirq === 1'b0 && len < 900)
      begin
         len++;
         @(posedge clk);
      end
      if (len >= 900)
      begin
         n_mismatch++;
         $display("Error %0t periodic line stuck low", $time);
         finish_test;
      end
   endtask : fire
   function automatic logic [7:0] exp_len(input int k, int r, logic g);
      return (g && k == r) ? 8'(PL) : 8'h00;
   endfunction : exp_len
   task automatic finish_test;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test
   initial
   begin
      {rst_n, run_c, slp, ev} = '0;
      void'($urandom(20696));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      host_i.rd(8'h11, d);
      cmp(d, 8'h80);
      host_i.rd(8'h20, d);
      cmp(d, 8'h00);
      host_i.wr(8'h11, 8'h80);
      host_i.rd(8'h11, d);
      cmp(d, 8'h00);
      $display("reset test done");
      repeat (8)
      begin
         {en, p} = 3'($urandom);
         e = $urandom % 4;
         host_i.wr(8'h12, {3'($urandom), 2'h0, en, p});
         host_i.rd(8'h12, d);
         cmp(d, {5'h00, en, p});
         fire(e);
         cmp(8'(len), exp_len(e, p, en));
         host_i.rd(8'h11, d);
         cmp(d, 8'h04 << e);
      end
      $display("period test done");
      host_i.wr(8'h12, 8'h08);
      fire(4);
      cmp({7'h00, airq}, 8'h00);
      host_i.rd(8'h11, d);
      cmp(d, 8'h40);
      host_i.wr(8'h11, 8'h40);
      fire(5);
      cmp({7'h00, airq}, 8'h01);
      $display("alarm test done");
      host_i.wr(8'h12, 8'h14);
      slp <= 1'b1;
      fire(0);
      cmp(8'(len), 8'h00);
      slp <= 1'b0;
      fire(5);
      cmp(8'(len), 8'(PL));
      $display("sleep test done");
      run_c <= 1'b1;
      for (e = 0; e < 400 && run_st !== 1'b1; e++)
         @(posedge clk);
      cmp({7'h00, run_st}, 8'h01);
      host_i.rd(8'h11, d);
      cmp(d, 8'h06);
      run_c <= 1'b0;
      for (e = 0; e < 400 && run_st !== 1'b0; e++)
         @(posedge clk);
      cmp({7'h00, run_st}, 8'h00);
      host_i.rd(8'h11, d);
      cmp(d, 8'h00);
      $display("run test done");
      finish_test;
   end
endmodule : tb
